// ==== core/pdx_regs.svh ====
// Constants of the power-down exit and pin hold block.
// Assumes a single 25 MHz clock and an active-low asynchronous reset.
`ifndef PDX_REGS_SVH
`define PDX_REGS_SVH
`define PDX_CFG_PWD_BIT 5
`define PDX_ES_OFF 2'b00
`define PDX_ES_HIGH 2'b01
`define PDX_ES_LOW 2'b10
`define PDX_ES_ANY 2'b11
`define PDX_WAKE_MIN_NS 40
`define PDX_CLK_NS 40
`define PDX_WAKE_MIN_CYC ((`PDX_WAKE_MIN_NS + `PDX_CLK_NS - 1) / `PDX_CLK_NS)
`define PDX_ALT_RST 16'h0000
`endif

// ==== core/pdx_pkg.sv ====
// Types of the power-down exit and pin hold block.
// Assumes nothing beyond the header of constants.
package pdx_pkg;
	typedef enum logic [3:0] {
		PDX_RUN = 4'b0001,
		PDX_IDLE = 4'b0010,
		PDX_PD = 4'b0100,
		PDX_WAKE = 4'b1000
	} pdx_state_t;
endpackage : pdx_pkg

// ==== core/pdx_sync2.sv ====
// Two flop synchroniser for pin inputs.
// Assumes the destination runs on ref_clk.
`timescale 1ns/100ps
module pdx_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : pdx_sync2

// ==== core/pdx_wake_chan.sv ====
// One fast interrupt channel of the power-down wake detector.
// Assumes a synchronised level input and the edge select field.
`timescale 1ns/100ps
`include "pdx_regs.svh"
module pdx_wake_chan (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic lvl,
	input wire logic [1:0] sel,
	input wire logic snap,
	output logic inactive,
	output logic wake
);
	logic ref_q;
	// Level seen at entry, used for the any-change code
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_q <= 1'b0;
		end else if (snap) begin
			ref_q <= lvl;
		end
	end
	// Pure level compare, no edge detector
	assign wake = (sel == `PDX_ES_HIGH) ? lvl :
		(sel == `PDX_ES_LOW) ? !lvl :
		(sel == `PDX_ES_ANY) ? (lvl != ref_q) : 1'b0;
	assign inactive = (sel == `PDX_ES_HIGH) ? !lvl :
		(sel == `PDX_ES_LOW) ? lvl : 1'b1;
endmodule : pdx_wake_chan

// ==== core/pdx_top.sv ====
// Power-down exit sequencer and low-power pin hold.
// Assumes CPU strobes on ref_clk; pins are synchronised here.
`timescale 1ns/100ps
`include "pdx_regs.svh"
module pdx_top #(
	parameter int NIRQ = 8,
	parameter int NCS = 5,
	parameter int WAKE_MIN_CYC = `PDX_WAKE_MIN_CYC
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ext_reset_in_n,
	input wire logic [NIRQ-1:0] fast_ext_irq_in,
	input wire logic nmi_in_n,
	input wire logic [15:0] system_config_reg,
	input wire logic [2*NIRQ-1:0] edge_select_field,
	input wire logic [NIRQ-1:0] irq_enable_bit,
	input wire logic [NIRQ-1:0] irq_clear,
	input wire logic power_down_instr,
	input wire logic idle_instr,
	input wire logic idle_exit,
	input wire logic end_init_instr,
	input wire logic next_instr_done,
	input wire logic delay_cap_pin,
	input wire logic ext_bus_en,
	input wire logic bus_demux,
	input wire logic bus_mux8,
	input wire logic [23:0] last_addr,
	input wire logic last_bhe,
	input wire logic bus_access,
	input wire logic xper_access,
	input wire logic [NCS-1:0] cs_enabled,
	input wire logic [NCS-1:0] cs_hit,
	input wire logic [7:0] seg_pin_sel,
	input wire logic [7:0] p0h_latch,
	input wire logic [7:0] p0l_latch,
	input wire logic [15:0] p1_latch,
	input wire logic [7:0] p4_latch,
	input wire logic [15:0] alt_sel,
	input wire logic [15:0] alt_live,
	input wire logic [15:0] gpio_latch,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_pll_en,
	output logic rpd_pulldown_en,
	output logic clock_hold_flop,
	output logic [NIRQ-1:0] irq_request_flag,
	output logic isr_call,
	output logic low_power,
	output logic [7:0] port0_upper_byte,
	output logic [7:0] port0_upper_oe,
	output logic [7:0] port0_lower_byte,
	output logic [7:0] port0_lower_oe,
	output logic [15:0] port_one_pins,
	output logic [7:0] port_four_pins,
	output logic [15:0] gen_out_pins,
	output logic byte_high_enable,
	output logic wr_n,
	output logic rd_n,
	output logic ale,
	output logic reset_out_pin,
	output logic [NCS-1:0] chip_select_outs
);
	pdx_pkg::pdx_state_t st_q, st_d;
	logic [NIRQ-1:0] irq_s;
	logic [2:0] misc_s;
	logic rst_s, nmi_s, rpd_s;
	logic [NIRQ-1:0] inactive_w, wake_w, wake_en_w;
	logic [NIRQ-1:0] wake_seen_q, wake_seen_d;
	logic [7:0] lvl_cnt_q;
	logic interruptible_w, entry_ok_w, any_wake_w, wake_ok_w;
	logic hold_q, osc_q, end_init_instr_q, xper_q, bhe_q, pend_isr_q;
	logic [15:0] alt_frz_q;
	logic [NCS-1:0] cs_q;
	logic [23:0] addr_q;
	logic active_w;
	logic st_run_w, st_idle_w, st_pd_w, st_wake_w;
	logic pd_entry_w, wake_fire_w, resume_w, isr_due_w, snap_bus_w;

	pdx_sync2 #(.W(NIRQ)) u_sync_irq (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d(fast_ext_irq_in),
		.q(irq_s)
	);
	// Reset pin, NMI and delay detector share one synchroniser
	pdx_sync2 #(.W(3)) u_sync_misc (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d({ext_reset_in_n, nmi_in_n, delay_cap_pin}),
		.q(misc_s)
	);
	assign rst_s = !misc_s[2];
	assign nmi_s = !misc_s[1];
	assign rpd_s = misc_s[0];

	for (genvar i = 0; i < NIRQ; i++) begin : g_chan
		pdx_wake_chan u_chan (
			.ref_clk(ref_clk),
			.arst_n(arst_n),
			.lvl(irq_s[i]),
			.sel(edge_select_field[2*i+1:2*i]),
			.snap(st_run_w),
			.inactive(inactive_w[i]),
			.wake(wake_w[i])
		);
	end

	assign interruptible_w = system_config_reg[`PDX_CFG_PWD_BIT];
	// Entry gate: NMI low if protected, all wake inputs inactive otherwise
	assign entry_ok_w = interruptible_w ? (&inactive_w) : nmi_s;
	// Enable bits deliberately not used here
	assign wake_en_w = interruptible_w ? wake_w : '0;
	assign any_wake_w = |wake_en_w;
	// Minimum width filter covers the 40 ns pulse the far side guarantees
	assign wake_ok_w = any_wake_w && (lvl_cnt_q >= 8'(WAKE_MIN_CYC - 1));

	// State decode shared by the processes below
	assign st_run_w = st_q == pdx_pkg::PDX_RUN;
	assign st_idle_w = st_q == pdx_pkg::PDX_IDLE;
	assign st_pd_w = st_q == pdx_pkg::PDX_PD;
	assign st_wake_w = st_q == pdx_pkg::PDX_WAKE;
	assign pd_entry_w = st_run_w && st_d == pdx_pkg::PDX_PD;
	assign wake_fire_w = st_pd_w && wake_ok_w;
	assign resume_w = st_wake_w && !rpd_s;
	assign isr_due_w = wake_fire_w && |(wake_en_w & irq_enable_bit);
	assign snap_bus_w = st_run_w && bus_access && !xper_access;

	always_comb begin
		st_d = st_q;
		case (st_q)
			pdx_pkg::PDX_RUN: begin
				if (power_down_instr && entry_ok_w) begin
					st_d = pdx_pkg::PDX_PD;
				end else if (idle_instr) begin
					st_d = pdx_pkg::PDX_IDLE;
				end
			end
			pdx_pkg::PDX_IDLE: begin
				if (idle_exit) begin
					st_d = pdx_pkg::PDX_RUN;
				end
			end
			pdx_pkg::PDX_PD: begin
				if (wake_ok_w) begin
					st_d = pdx_pkg::PDX_WAKE;
				end
			end
			pdx_pkg::PDX_WAKE: begin
				if (!rpd_s) begin
					st_d = pdx_pkg::PDX_RUN;
				end
			end
			default: st_d = pdx_pkg::PDX_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl_cnt_q <= 8'h00;
		end else if (st_pd_w && any_wake_w) begin
			// Saturates so a long level cannot wrap back under the filter
			lvl_cnt_q <= (lvl_cnt_q == 8'hff) ? lvl_cnt_q : lvl_cnt_q + 8'h01;
		end else begin
			lvl_cnt_q <= 8'h00;
		end
	end

	// Reset pin aborts power-down and idle; caller keeps it low until PLL settles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= pdx_pkg::PDX_RUN;
		end else if (rst_s) begin
			st_q <= pdx_pkg::PDX_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// Clock-hold flop: set on entry, cleared by the threshold detector
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_q <= 1'b0;
		end else if (rst_s) begin
			hold_q <= 1'b0;
		end else if (pd_entry_w) begin
			hold_q <= 1'b1;
		end else if (resume_w) begin
			hold_q <= 1'b0;
		end
	end

	// Oscillator and PLL run except between entry and the wake event
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_q <= 1'b1;
		end else if (rst_s) begin
			osc_q <= 1'b1;
		end else if (pd_entry_w) begin
			osc_q <= 1'b0;
		end else if (wake_fire_w) begin
			osc_q <= 1'b1;
		end
	end

	assign active_w = !hold_q;
	assign cpu_clk_en = active_w && st_q != pdx_pkg::PDX_IDLE;
	assign periph_clk_en = active_w;
	assign osc_pll_en = osc_q;
	assign rpd_pulldown_en = st_q == pdx_pkg::PDX_WAKE;
	assign clock_hold_flop = hold_q;
	assign low_power = st_q != pdx_pkg::PDX_RUN;

	// Request flags: wake sets, software clears, set wins
	always_comb begin
		wake_seen_d = irq_request_flag & ~irq_clear;
		if (wake_fire_w) begin
			wake_seen_d = wake_seen_d | wake_en_w;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_request_flag <= '0;
		end else begin
			irq_request_flag <= wake_seen_d;
		end
	end

	// Service call waits for one instruction after resume
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_isr_q <= 1'b0;
			isr_call <= 1'b0;
		end else begin
			isr_call <= 1'b0;
			if (isr_due_w) begin
				pend_isr_q <= 1'b1;
			end else if (pend_isr_q && active_w && next_instr_done) begin
				pend_isr_q <= 1'b0;
				isr_call <= 1'b1;
			end
		end
	end

	// End-of-init latch for the reset output pin
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			end_init_instr_q <= 1'b0;
		end else if (st_run_w && end_init_instr) begin
			end_init_instr_q <= 1'b1;
		end
	end

	// Last access target: extension peripheral or external bus
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			xper_q <= 1'b0;
		end else if (st_run_w && xper_access) begin
			xper_q <= 1'b1;
		end else if (snap_bus_w) begin
			xper_q <= 1'b0;
		end
	end

	// Bus history captured only while running
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bhe_q <= 1'b1;
			cs_q <= '0;
			addr_q <= 24'h000000;
		end else if (snap_bus_w) begin
			bhe_q <= last_bhe;
			cs_q <= cs_hit & cs_enabled;
			addr_q <= last_addr;
		end
	end

	// Alternate outputs stop tracking once the clocks are held
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_frz_q <= `PDX_ALT_RST;
		end else if (st_run_w || st_idle_w) begin
			alt_frz_q <= alt_live;
		end
	end

	// Pins below are pure selects of flops and latch ports
	logic lp_bus_w;
	assign lp_bus_w = low_power && ext_bus_en;
	// Idle follows peripheral; power-down shows the frozen value
	assign gen_out_pins = (alt_sel & (hold_q ? alt_frz_q : alt_live)) |
		(~alt_sel & gpio_latch);
	assign wr_n = 1'b1;
	assign rd_n = 1'b1;
	assign ale = 1'b0;
	assign byte_high_enable = lp_bus_w ? bhe_q : 1'b1;
	assign port0_upper_byte = lp_bus_w ? addr_q[15:8] : p0h_latch;
	assign port0_upper_oe = (lp_bus_w && !bus_mux8) ? 8'h00 : 8'hff;
	assign port0_lower_byte = p0l_latch;
	assign port0_lower_oe = lp_bus_w ? 8'h00 : 8'hff;
	assign port_one_pins = (lp_bus_w && bus_demux) ? addr_q[15:0] : p1_latch;
	assign port_four_pins = lp_bus_w ?
		((seg_pin_sel & addr_q[23:16]) | (~seg_pin_sel & p4_latch)) : p4_latch;
	assign reset_out_pin = end_init_instr_q;
	// Extension access leaves every select high
	assign chip_select_outs = (lp_bus_w && !xper_q) ? ~cs_q : {NCS{1'b1}};
endmodule : pdx_top

// ==== verification/pdx_props.sv ====
// Port checker of the power-down exit sequencer and pin hold.
// Assumes one ref_clk domain; bound to pdx_top at the foot.
`timescale 1ns/100ps
module pdx_props #(
	parameter int NIRQ = 8
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ext_reset_in_n,
	input wire logic [NIRQ-1:0] fast_ext_irq_in,
	input wire logic [15:0] system_config_reg,
	input wire logic [2*NIRQ-1:0] edge_select_field,
	input wire logic power_down_instr,
	input wire logic end_init_instr,
	input wire logic delay_cap_pin,
	input wire logic ext_bus_en,
	input wire logic bus_mux8,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic osc_pll_en,
	input wire logic clock_hold_flop,
	input wire logic low_power,
	input wire logic [7:0] port0_upper_oe,
	input wire logic [7:0] port0_lower_oe,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic ale,
	input wire logic reset_out_pin
);
	logic end_init_instr_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) end_init_instr_q <= 1'b0;
		else if (end_init_instr) end_init_instr_q <= 1'b1;
	end
	sequence s_pd_held;
		clock_hold_flop && !osc_pll_en;
	endsequence
	// Reset pin quiet long enough that its synchroniser cannot wake us
	sequence s_prot_pd;
		ext_reset_in_n [*4] ##0 s_pd_held ##0 !system_config_reg[5];
	endsequence
	property p_enter;
		$rose(clock_hold_flop) |-> $past(power_down_instr) && !osc_pll_en && low_power;
	endproperty
	property p_gated;
		clock_hold_flop |-> !cpu_clk_en && !periph_clk_en;
	endproperty
	property p_wake;
		s_pd_held ##0 (system_config_reg[5] && edge_select_field[3:2] == 2'b01
			&& fast_ext_irq_in[1]) |-> ##[1:4] osc_pll_en;
	endproperty
	property p_prot;
		s_prot_pd |=> !osc_pll_en;
	endproperty
	property p_resume;
		$fell(clock_hold_flop) && ext_reset_in_n |-> !$past(delay_cap_pin, 3) && cpu_clk_en;
	endproperty
	property p_reset_out_pin;
		low_power |-> reset_out_pin == end_init_instr_q;
	endproperty
	property p_strobe;
		low_power && ext_bus_en |-> wr_n && rd_n && !ale;
	endproperty
	property p_port0;
		low_power && ext_bus_en |-> port0_lower_oe == 8'h00 && port0_upper_oe == {8{bus_mux8}};
	endproperty
	a_enter: assert property (p_enter) else $error("entry not taken cleanly");
	a_gated: assert property (p_gated) else $error("clock ran while held");
	a_wake: assert property (p_wake) else $error("no wake on high level");
	a_prot: assert property (p_prot) else $error("protected mode woke");
	a_resume: assert property (p_resume) else $error("resume without delay pin");
	a_reset_out_pin: assert property (p_reset_out_pin) else $error("reset output level wrong");
	a_strobe: assert property (p_strobe) else $error("bus strobe active");
	a_port0: assert property (p_port0) else $error("port0 drive wrong");
endmodule : pdx_props
bind pdx_top pdx_props #(.NIRQ(NIRQ)) u_pdx_props (.*);

// ==== verification/pdx_ext_src.sv ====
// Model of the external reset source and fast interrupt sources.
// Assumes level commands from the bench on ref_clk.
`timescale 1ns/100ps
module pdx_ext_src (
	input wire logic ref_clk,
	input wire logic [7:0] irq_req,
	input wire logic rst_req,
	output logic [7:0] fast_ext_irq_in,
	output logic ext_reset_in_n
);
	logic [5:0] rst_cnt_q = 6'h00;
	initial fast_ext_irq_in = 8'h00;
	initial ext_reset_in_n = 1'b1;
	// Levels move on edges only, so none lasts under one 40 ns period
	always @(posedge ref_clk) fast_ext_irq_in <= irq_req;
	// Reset stays low well past oscillator and PLL start-up
	always @(posedge ref_clk) begin
		if (rst_req) rst_cnt_q <= 6'h3f;
		else if (rst_cnt_q != 6'h00) rst_cnt_q <= rst_cnt_q - 6'h01;
		ext_reset_in_n <= !(rst_req || rst_cnt_q != 6'h00);
	end
endmodule : pdx_ext_src

// ==== verification/tb_top.sv ====
// Self-checking bench of the power-down exit sequencer and pin hold.
// Assumes pdx_top defaults and the source model on its pins.
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 1'b0, arst_n, nmi_in_n, power_down_instr, idle_instr, idle_exit, end_init_instr;
	logic next_instr_done, delay_cap_pin, ext_bus_en, bus_demux, bus_mux8, last_bhe, bus_access;
	logic xper_access, rst_req, cpu_clk_en, periph_clk_en, osc_pll_en, rpd_pulldown_en, isr_call;
	logic clock_hold_flop, low_power, byte_high_enable, wr_n, rd_n, ale, reset_out_pin;
	logic ext_reset_in_n;
	logic [7:0] irq_req, irq_enable_bit, irq_clear, seg_pin_sel, p0h_latch, p0l_latch, p4_latch;
	logic [7:0] fast_ext_irq_in, irq_request_flag, port0_upper_byte, port0_upper_oe;
	logic [7:0] port0_lower_byte, port0_lower_oe, port_four_pins;
	logic [15:0] system_config_reg, edge_select_field, p1_latch, alt_sel, alt_live, gpio_latch;
	logic [15:0] port_one_pins, gen_out_pins, frz_exp;
	logic [23:0] last_addr;
	logic [4:0] cs_enabled, cs_hit, chip_select_outs;
	logic [7:0] exp_q[$];
	int bad_count = 0, checks_done = 0, seed, k;
	pdx_top u_pdx_top (.*);
	pdx_ext_src u_pdx_ext_src (.*);
	always #20 ref_clk = ~ref_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("mismatches %0d checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	function automatic logic pick(input logic w);
		return w ? clock_hold_flop : osc_pll_en;
	endfunction : pick
	task automatic wait_sig(input logic w, input logic v, input int lim);
		for (int n = 0; n < lim && pick(w) !== v; n++) tick(1);
		if (pick(w) !== v) begin
			bad_count++;
			print_verdict();
		end
	endtask : wait_sig
	task automatic pd_enter;
		power_down_instr = 1'b1;
		tick(1);
		power_down_instr = 1'b0;
		tick(2);
	endtask : pd_enter
	// Flags seen at resume are matched against the oldest note
	always @(posedge ref_clk) begin
		if (arst_n && $fell(clock_hold_flop)) begin
			chk(irq_request_flag, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		end
	end
	initial begin
		seed = 56;
		{arst_n, nmi_in_n, delay_cap_pin, power_down_instr, idle_instr, idle_exit} = 6'b011000;
		{end_init_instr, next_instr_done, ext_bus_en, bus_demux, bus_mux8, last_bhe} = '0;
		{bus_access, xper_access, rst_req, irq_req, irq_enable_bit, irq_clear} = '0;
		{seg_pin_sel, system_config_reg, edge_select_field, alt_sel, cs_enabled, cs_hit} = '0;
		{p0h_latch, p0l_latch, p4_latch, p1_latch} = 40'({$random(seed), $random(seed)});
		{alt_live, gpio_latch} = $random(seed);
		last_addr = 24'($random(seed));
		repeat (10) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		// Protected mode: only the reset pin may end power-down
		nmi_in_n = 1'b0;
		edge_select_field = 16'h0004;
		alt_sel = 16'h00ff;
		frz_exp = (alt_live & 16'h00ff) | (gpio_latch & 16'hff00);
		tick(4);
		pd_enter();
		chk(low_power, 1'b1);
		alt_live = ~alt_live;
		irq_req = 8'h02;
		tick(8);
		chk(osc_pll_en, 1'b0);
		chk(gen_out_pins, frz_exp);
		exp_q.push_back(8'h00);
		rst_req = 1'b1;
		tick(1);
		rst_req = 1'b0;
		wait_sig(1'b1, 1'b0, 80);
		{irq_req, nmi_in_n, system_config_reg} = {8'h00, 1'b1, 16'h0020};
		tick(70);
		for (k = 1; k < 4; k++) begin
			edge_select_field = 16'(k) << (2 * k);
			irq_enable_bit = (k == 3) ? 8'h08 : 8'h00;
			irq_req = {7'h00, k == 2} << k;
			irq_req[0] = 1'($random(seed));
			tick(4);
			pd_enter();
			chk(low_power, 1'b1);
			exp_q.push_back(8'h01 << k);
			irq_req[0] = 1'($random(seed));
			tick(3);
			chk(osc_pll_en, 1'b0);
			irq_req[k] = ~irq_req[k];
			wait_sig(1'b0, 1'b1, 8);
			chk({rpd_pulldown_en, cpu_clk_en}, 2'b10);
			delay_cap_pin = 1'b0;
			wait_sig(1'b1, 1'b0, 8);
			chk({cpu_clk_en, isr_call}, 2'b10);
			next_instr_done = 1'b1;
			tick(1);
			{next_instr_done, delay_cap_pin, irq_clear} = {2'b01, 8'hff};
			chk(isr_call, k == 3);
			tick(1);
			irq_clear = 8'h00;
		end
		end_init_instr = 1'b1;
		tick(1);
		{end_init_instr, ext_bus_en, cs_enabled, cs_hit} = {2'b01, 5'h1f, 5'h04};
		{seg_pin_sel, alt_sel} = {8'h0f, 16'h00ff};
		for (k = 0; k < 2; k++) begin
			{bus_demux, bus_mux8, bus_access, xper_access} = {k == 0, k == 1, k == 0, k == 1};
			last_addr[15:0] = (k == 0) ? 16'($random(seed)) : last_addr[15:0];
			tick(1);
			{bus_access, xper_access, idle_instr} = 3'b001;
			tick(1);
			idle_instr = 1'b0;
			tick(1);
			chk(port_one_pins, k ? p1_latch : last_addr[15:0]);
			if (k == 1) chk(port0_upper_byte, last_addr[15:8]);
			chk(port_four_pins, (last_addr[23:16] & 8'h0f) | (p4_latch & 8'hf0));
			chk({byte_high_enable, reset_out_pin, wr_n}, 3'b011);
			chk(gen_out_pins, (alt_live & 16'h00ff) | (gpio_latch & 16'hff00));
			chk(chip_select_outs, k ? 5'h1f : 5'h1b);
			idle_exit = 1'b1;
			tick(1);
			idle_exit = 1'b0;
			tick(2);
		end
		print_verdict();
	end
endmodule : tb_top
